// file: iopc_pkg.sv
package iopc_pkg;
   localparam int unsigned IOPC_AW = 8;
   localparam int unsigned IOPC_DW = 16;
   localparam logic [7:0] IOPC_ADDR_CFG = 8'h03;
   localparam logic [7:0] IOPC_ADDR_STAT = 8'h10;
   localparam logic [7:0] IOPC_ADDR_MASK = 8'h11;
   localparam logic [15:0] IOPC_CFG_RESET = 16'h0000;
   localparam logic [15:0] IOPC_CFG_WMASK = 16'h07ee;
   localparam int unsigned IOPC_B_SYNC_CLR = 10;
   localparam int unsigned IOPC_B_ROUTE_HI = 9;
   localparam int unsigned IOPC_B_ROUTE_LO = 8;
   localparam int unsigned IOPC_B_LVL0 = 5;
   localparam int unsigned IOPC_B_DIR0 = 1;
   localparam logic [1:0] IOPC_ROUTE_NONE = 2'h0;
   localparam logic [1:0] IOPC_ROUTE_CLK = 2'h1;
   localparam logic [1:0] IOPC_ROUTE_PIN0 = 2'h2;
   localparam logic [1:0] IOPC_ROUTE_RDY = 2'h3;
   localparam int unsigned IOPC_NEV = 2;
   localparam int unsigned IOPC_EV_INT = 0;
   localparam int unsigned IOPC_EV_CLR = 1;
   localparam logic [1:0] IOPC_EV_RESET = 2'h0;
endpackage

// file: iopc_top.sv
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/100ps
// What this block does
// - With clear-on-sync enabled, a sync pin pulse empties the FIFO; otherwise nothing.
// - Two-bit routing field picks the interrupt pin; code 00 routes nowhere.
// - FIFO disabled means data-ready is the interrupt event, else the FIFO interrupt.
// - Code 01 drives the interrupt on the clock pin, overriding clock-source output.
// - Code 10 drives the interrupt on pin zero, overriding its direction bit.
// - Code 11 puts only data-ready on the serial-out/ready pin.
// - Each output level bit drives its pin only while its direction selects output.
// - Pin two direction 0 keeps the input role, 1 makes it a driven output.
// - Standby indicator enable makes pin two the standby output, overriding its settings.
// - Pin one direction clear keeps the input role, set makes it an output.
// - Interrupt routed to pin zero takes highest priority over its own settings.
// - Config register sits at address 0x03 and resets to all zeros.
module iopc_top
   import iopc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [IOPC_AW-1:0] addr,
   input wire logic [IOPC_DW-1:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [IOPC_DW-1:0] rdata,
   input wire logic sync_pin_b,
   input wire logic fifo_enable,
   input wire logic data_ready,
   input wire logic fifo_irq,
   input wire logic clk_src_level,
   input wire logic clk_src_oe,
   input wire logic standby_indicator_enable,
   input wire logic standby_level,
   output logic fifo_clear,
   output logic clk_pin_out,
   output logic clk_pin_oe,
   output logic rdy_pin_select,
   output logic rdy_pin_level,
   output logic [2:0] gp_pin_out,
   output logic [2:0] gp_pin_oe,
   output logic irq
);
   logic [1:0] rst_pipe_q;
   logic rst_n_q;
   logic [2:0] sync_pipe_q;
   logic sync_stable_q;
   logic [15:0] cfg_q;
   logic [IOPC_NEV-1:0] stat_q, stat_d, mask_q;
   logic int_event_q;
   logic fifo_clear_d;

   // Reset released through two flops; assertion stays asynchronous
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_pipe_q <= 2'h0;
      end else begin
         rst_pipe_q <= {rst_pipe_q[0], 1'b1};
      end
   end
   assign rst_n_q = rst_pipe_q[1];

   wire cfg_sel = (addr == IOPC_ADDR_CFG);
   wire stat_sel = (addr == IOPC_ADDR_STAT);
   wire mask_sel = (addr == IOPC_ADDR_MASK);
   wire fifo_clear_on_sync_enable = cfg_q[IOPC_B_SYNC_CLR];
   wire [1:0] irq_route = cfg_q[IOPC_B_ROUTE_HI:IOPC_B_ROUTE_LO];
   wire [2:0] out_level = cfg_q[IOPC_B_LVL0 +: 3];
   wire [2:0] direction = cfg_q[IOPC_B_DIR0 +: 3];
   wire int_event = fifo_enable ? fifo_irq : data_ready;
   // Stable level moves only when the second and third stages agree
   wire sync_next = (sync_pipe_q[1] == sync_pipe_q[2]) ? sync_pipe_q[2] : sync_stable_q;
   wire sync_fall = sync_stable_q & ~sync_next;
   wire [IOPC_NEV-1:0] events;
   assign events[IOPC_EV_INT] = int_event & ~int_event_q;
   assign events[IOPC_EV_CLR] = fifo_clear_d;
   assign fifo_clear_d = sync_fall & fifo_clear_on_sync_enable;
   // New events win over a same-cycle write-one clear
   wire [IOPC_NEV-1:0] w1c = (wr_stb && stat_sel) ? wdata[IOPC_NEV-1:0] : '0;
   assign stat_d = (stat_q & ~w1c) | events;
   wire [IOPC_DW-1:0] rd_mux = cfg_sel ? cfg_q :
                               stat_sel ? {{(IOPC_DW-IOPC_NEV){1'b0}}, stat_q} :
                               mask_sel ? {{(IOPC_DW-IOPC_NEV){1'b0}}, mask_q} : '0;

   // Pin selection, decided before the output flops
   wire clk_out_d = (irq_route == IOPC_ROUTE_CLK) ? int_event : clk_src_level;
   wire clk_oe_d = (irq_route == IOPC_ROUTE_CLK) ? 1'b1 : clk_src_oe;
   wire rdy_sel_d = (irq_route == IOPC_ROUTE_RDY);
   wire pin0_irq = (irq_route == IOPC_ROUTE_PIN0);
   wire [2:0] gp_out_d, gp_oe_d;
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_pin
         if (gi == 0) begin : g_p0
            assign gp_out_d[gi] = pin0_irq ? int_event : out_level[gi];
            assign gp_oe_d[gi] = pin0_irq | direction[gi];
         end else if (gi == 2) begin : g_p2
            assign gp_out_d[gi] = standby_indicator_enable ? standby_level : out_level[gi];
            assign gp_oe_d[gi] = standby_indicator_enable | direction[gi];
         end else begin : g_p1
            assign gp_out_d[gi] = out_level[gi];
            assign gp_oe_d[gi] = direction[gi];
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sync_pipe_q <= 3'h7;
         sync_stable_q <= 1'b1;
      end else begin
         sync_pipe_q <= {sync_pipe_q[1:0], sync_pin_b};
         sync_stable_q <= sync_next;
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cfg_q <= IOPC_CFG_RESET;
      end else if (wr_stb && cfg_sel) begin
         // Reserved bits are never stored, so they cannot reach a pin
         cfg_q <= wdata & IOPC_CFG_WMASK;
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         mask_q <= IOPC_EV_RESET;
      end else if (wr_stb && mask_sel) begin
         mask_q <= wdata[IOPC_NEV-1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         stat_q <= IOPC_EV_RESET;
      end else begin
         stat_q <= stat_d;
      end
   end

   // An event level already high when reset ends is seen as one rise
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         int_event_q <= 1'b0;
      end else begin
         int_event_q <= int_event;
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rdata <= '0;
      end else begin
         // Read data stand for one cycle only, zero between reads
         rdata <= rd_stb ? rd_mux : '0;
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         fifo_clear <= 1'b0;
      end else begin
         fifo_clear <= fifo_clear_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         clk_pin_out <= 1'b0;
         clk_pin_oe <= 1'b0;
      end else begin
         clk_pin_out <= clk_out_d;
         clk_pin_oe <= clk_oe_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rdy_pin_select <= 1'b0;
         rdy_pin_level <= 1'b0;
      end else begin
         rdy_pin_select <= rdy_sel_d;
         rdy_pin_level <= rdy_sel_d & data_ready;
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         gp_pin_out <= 3'h0;
         gp_pin_oe <= 3'h0;
      end else begin
         gp_pin_out <= gp_out_d;
         gp_pin_oe <= gp_oe_d;
      end
   end

   // Next status is used so the interrupt rises with its status bit
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         irq <= 1'b0;
      end else begin
         irq <= |(stat_d & mask_q);
      end
   end

   a_sync_clear_on: assert property (@(posedge clk) disable iff (!rst_n_q)
      (sync_fall && fifo_clear_on_sync_enable) |=> fifo_clear)
      else $error("sync pulse did not clear fifo");
   a_sync_clear_off: assert property (@(posedge clk) disable iff (!rst_n_q)
      fifo_clear |-> $past(fifo_clear_on_sync_enable))
      else $error("fifo cleared while disabled");
   a_route_none: assert property (@(posedge clk) disable iff (!rst_n_q)
      ($past(irq_route) == IOPC_ROUTE_NONE && !$past(standby_indicator_enable))
      |-> (gp_pin_oe == $past(direction) && !rdy_pin_select))
      else $error("route none still drives a pin");
   a_event_source: assert property (@(posedge clk) disable iff (!rst_n_q)
      (irq_route == IOPC_ROUTE_PIN0 && !fifo_enable) |=> gp_pin_out[0] == $past(data_ready))
      else $error("data ready not used as event");
   a_clk_route: assert property (@(posedge clk) disable iff (!rst_n_q)
      (irq_route == IOPC_ROUTE_CLK) |=> (clk_pin_oe && clk_pin_out == $past(int_event)))
      else $error("clock pin not carrying interrupt");
   a_pin0_route: assert property (@(posedge clk) disable iff (!rst_n_q)
      (irq_route == IOPC_ROUTE_PIN0 && !direction[0]) |=> gp_pin_oe[0])
      else $error("pin zero not driven for interrupt");
   a_rdy_only: assert property (@(posedge clk) disable iff (!rst_n_q)
      (irq_route == IOPC_ROUTE_RDY && fifo_enable && !data_ready) |=> !rdy_pin_level)
      else $error("fifo interrupt leaked onto ready pin");
   a_gp_level: assert property (@(posedge clk) disable iff (!rst_n_q)
      (direction[1] && wr_stb == 1'b0) |=> (gp_pin_oe[1] && gp_pin_out[1] == $past(out_level[1])))
      else $error("pin one level mismatch");
   a_pin2_dir: assert property (@(posedge clk) disable iff (!rst_n_q)
      (!standby_indicator_enable && !direction[2]) |=> !gp_pin_oe[2])
      else $error("pin two driven in input role");
   a_standby_ovr: assert property (@(posedge clk) disable iff (!rst_n_q)
      standby_indicator_enable |=> (gp_pin_oe[2] && gp_pin_out[2] == $past(standby_level)))
      else $error("standby override failed");
   a_pin1_dir: assert property (@(posedge clk) disable iff (!rst_n_q)
      !direction[1] |=> !gp_pin_oe[1])
      else $error("pin one driven in input role");
   a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n_q)
      (cfg_q & ~IOPC_CFG_WMASK) == 16'h0000)
      else $error("reserved bits not zero");
   a_cfg_readback: assert property (@(posedge clk) disable iff (!rst_n_q)
      (rd_stb && cfg_sel) |=> rdata == $past(cfg_q))
      else $error("config readback wrong");

   // Filter, pin and register bus checks
   a_sync_filter: assert property (@(posedge clk) disable iff (!rst_n_q)
      (sync_pipe_q[1] != sync_pipe_q[2]) |=> $stable(sync_stable_q))
      else $error("sync level moved before stages agreed");
   a_clear_single: assert property (@(posedge clk) disable iff (!rst_n_q)
      fifo_clear |=> !fifo_clear)
      else $error("fifo clear longer than one cycle");
   a_clear_disabled: assert property (@(posedge clk) disable iff (!rst_n_q)
      !fifo_clear_on_sync_enable |=> !fifo_clear)
      else $error("fifo cleared with clear on sync off");
   a_event_fifo: assert property (@(posedge clk) disable iff (!rst_n_q)
      (irq_route == IOPC_ROUTE_PIN0 && fifo_enable) |=> gp_pin_out[0] == $past(fifo_irq))
      else $error("fifo interrupt not used as event");
   a_clk_passthru: assert property (@(posedge clk) disable iff (!rst_n_q)
      (irq_route != IOPC_ROUTE_CLK)
      |=> (clk_pin_out == $past(clk_src_level) && clk_pin_oe == $past(clk_src_oe)))
      else $error("clock pin lost its clock source drive");
   a_rdy_level: assert property (@(posedge clk) disable iff (!rst_n_q)
      (irq_route == IOPC_ROUTE_RDY)
      |=> (rdy_pin_select && rdy_pin_level == $past(data_ready)))
      else $error("ready pin not carrying data ready");
   a_rdy_idle: assert property (@(posedge clk) disable iff (!rst_n_q)
      (irq_route != IOPC_ROUTE_RDY) |=> (!rdy_pin_select && !rdy_pin_level))
      else $error("ready pin selected without its route");
   a_pin0_irq: assert property (@(posedge clk) disable iff (!rst_n_q)
      (irq_route == IOPC_ROUTE_PIN0)
      |=> (gp_pin_oe[0] && gp_pin_out[0] == $past(int_event)))
      else $error("pin zero not carrying interrupt");
   a_pin0_level: assert property (@(posedge clk) disable iff (!rst_n_q)
      (irq_route != IOPC_ROUTE_PIN0)
      |=> (gp_pin_oe[0] == $past(direction[0]) && gp_pin_out[0] == $past(out_level[0])))
      else $error("pin zero level or direction wrong");
   a_pin2_level: assert property (@(posedge clk) disable iff (!rst_n_q)
      !standby_indicator_enable
      |=> (gp_pin_oe[2] == $past(direction[2]) && gp_pin_out[2] == $past(out_level[2])))
      else $error("pin two level or direction wrong");
   a_reserved_read: assert property (@(posedge clk) disable iff (!rst_n_q)
      (rd_stb && cfg_sel) |=> (rdata & ~IOPC_CFG_WMASK) == 16'h0000)
      else $error("reserved bits read nonzero");
   a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n_q)
      !rd_stb |=> rdata == '0)
      else $error("read data outside a read");
   a_set_wins: assert property (@(posedge clk) disable iff (!rst_n_q)
      fifo_clear_d |=> stat_q[IOPC_EV_CLR])
      else $error("clear event lost against write");
   a_w1c_clear: assert property (@(posedge clk) disable iff (!rst_n_q)
      (wr_stb && stat_sel && wdata[IOPC_EV_INT] && !events[IOPC_EV_INT])
      |=> !stat_q[IOPC_EV_INT])
      else $error("status bit not cleared by write");
   a_irq_level: assert property (@(posedge clk) disable iff (!rst_n_q)
      irq == |(stat_q & $past(mask_q)))
      else $error("interrupt level wrong");
   a_mask_gate: assert property (@(posedge clk) disable iff (!rst_n_q)
      (mask_q == IOPC_EV_RESET) |=> !irq)
      else $error("interrupt with all events masked");

   c_sync_clear: cover property (@(posedge clk) disable iff (!rst_n_q) fifo_clear);
   c_clk_route: cover property (@(posedge clk) disable iff (!rst_n_q)
      irq_route == IOPC_ROUTE_CLK && int_event);
   c_pin0_route: cover property (@(posedge clk) disable iff (!rst_n_q) pin0_irq && gp_pin_out[0]);
   c_irq_out: cover property (@(posedge clk) disable iff (!rst_n_q) irq);
   c_rdy_route: cover property (@(posedge clk) disable iff (!rst_n_q) rdy_pin_select && rdy_pin_level);
endmodule

// file: iopc_board.sv
`timescale 1ns/100ps
module iopc_board (
   input wire logic [2:0] gp_pin_out,
   input wire logic [2:0] gp_pin_oe,
   input wire logic clk_pin_out,
   input wire logic clk_pin_oe,
   output logic [2:0] gp_wire,
   output logic clk_wire);
   // General pins pulled up, clock pin pulled down: only a driven pin shows the other level
   assign gp_wire = (gp_pin_oe & gp_pin_out) | ~gp_pin_oe;
   assign clk_wire = clk_pin_oe & clk_pin_out;
endmodule

// file: iopc_top_test.sv
`timescale 1ns/100ps
module iopc_top_test;
   logic clk = 1'b0, rst_b = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, sync_pin_b = 1'b1;
   logic fifo_enable = 1'b0, data_ready = 1'b0, fifo_irq = 1'b0, clk_src_level = 1'b0;
   logic clk_src_oe = 1'b1, standby_indicator_enable = 1'b0, standby_level = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000, rdata, v;
   logic fifo_clear, clk_pin_out, clk_pin_oe, rdy_pin_select, rdy_pin_level, irq, clk_wire, s;
   logic [2:0] gp_pin_out, gp_pin_oe, gp_wire;
   logic [31:0] tbl [3] = '{32'h070c1404, 32'h060c1404, 32'h07080404};
   int fail_count = 0, check_count = 0;
   iopc_top i_dut (.*);
   iopc_board i_board (.*);
   wire logic [4:0] rt = {clk_wire, gp_pin_oe[0], gp_wire[0], rdy_pin_select, rdy_pin_level};
   initial forever #20 clk = ~clk;
   task automatic stop_test;
      if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(string n, logic [15:0] got, logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic acc(logic w, logic [7:0] a, logic [15:0] d, output logic [15:0] q);
      @(posedge clk);
      {addr, wdata} <= {a, d};
      {wr_stb, rd_stb} <= {w, !w};
      @(posedge clk);
      {wr_stb, rd_stb} <= 2'b00;
      #1 q = rdata;
   endtask
   // Pins sit behind the registered config, so three edges cover both stages
   task automatic cfg(logic [15:0] d);
      acc(1'b1, 8'h03, d, v);
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic pulse(output logic f);
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         sync_pin_b <= (i > 9);
         #1 f = (i > 0 && f) | fifo_clear;
      end
   endtask
   task automatic t_regs;
      acc(1'b0, 8'h03, 16'h0000, v);
      chk("cfg_reset", v, 16'h0000);
      acc(1'b1, 8'h03, 16'hffff, v);
      acc(1'b0, 8'h03, 16'h0000, v);
      chk("cfg_reserved", v, 16'h07ee);
      acc(1'b0, 8'h20, 16'h0000, v);
      chk("unmapped", v, 16'h0000);
   endtask
   task automatic t_gpio;
      cfg(16'h002e);
      chk("gp_drive", {gp_pin_oe, gp_wire}, 6'h39);
      @(posedge clk);
      standby_indicator_enable <= 1'b1;
      cfg(16'h00e0);
      chk("gp_input", gp_pin_oe[1:0], 2'h0);
      chk("standby", gp_wire, 3'h3);
      @(posedge clk);
      standby_indicator_enable <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("pin2_input", gp_pin_oe[2], 1'b0);
   endtask
   task automatic t_route;
      for (int m = 0; m < 3; m++) begin
         @(posedge clk);
         fifo_enable <= (m != 0);
         fifo_irq <= (m == 1);
         data_ready <= (m != 1);
         for (int c = 0; c < 4; c++) begin
            cfg({6'h00, c[1:0], 8'h00});
            chk("route", rt, tbl[m][8*c+:8]);
         end
      end
   endtask
   task automatic t_sync;
      acc(1'b1, 8'h11, 16'h0002, v);
      cfg(16'h0400);
      pulse(s);
      chk("clear_on", s, 1'b1);
      chk("irq_set", irq, 1'b1);
      acc(1'b0, 8'h11, 16'h0000, v);
      chk("mask", v, 16'h0002);
      acc(1'b0, 8'h10, 16'h0000, v);
      chk("status", v, 16'h0003);
      acc(1'b1, 8'h10, 16'h0003, v);
      acc(1'b0, 8'h10, 16'h0000, v);
      chk("status_clear", v, 16'h0000);
      cfg(16'h0000);
      chk("irq_clear", irq, 1'b0);
      pulse(s);
      chk("clear_off", s, 1'b0);
   endtask
   task automatic t_reset;
      cfg(16'h072e);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("reset_pins", {gp_pin_oe, clk_pin_oe, rdy_pin_select}, 5'h02);
      acc(1'b0, 8'h03, 16'h0000, v);
      chk("reset_cfg", v, 16'h0000);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      t_regs;
      t_gpio;
      t_route;
      t_sync;
      t_reset;
      stop_test;
   end
endmodule
